// File: verilog/txq_priority_rate_scheduler.v
// Contract
// - queue 2 strict mode: drain queue 2 before any lower queue.
// - queue 2 ratio mode: cap queue 2 at its field count per period; code exceeds it when only exhausted queues are pending.
// - queue 2 ratio field is bits 14:8, resets to 4.
// - queue 3 strict mode: drain queue 3 before lower queues.
// - queue 3 ratio mode: cap queue 3 at bits 6:0 per period; code exceeds it when only exhausted queues are pending.
// - queue 3 ratio field is bits 6:0, resets to 8.
// - queue 0 strict mode: serve queue 0 only after higher queues.
// - queue 0 ratio mode: cap queue 0 at bits 14:8 per period; code exceeds it when only exhausted queues are pending.
// - queue 0 ratio field is bits 14:8 of low register, resets to 1.
// - queue 1 strict mode: empty queue 1 before queue 0.
// - queue 1 ratio mode: cap queue 1 at bits 6:0 per period; code exceeds it when only exhausted queues are pending.
// - queue 1 ratio field is bits 6:0 of low register, resets to 2.
// - each network port has its own pair of rate registers.
// - priority order is queue 3, 2, 1, then 0.
//
// Implementation choice: the strobed register port.
`include "txq_sched_regs.vh"
`default_nettype none
module txq_priority_rate_scheduler #(
   parameter PERIOD_CYCLES = `PERIOD_CYCLES
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // register port
   input  wire [7:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata_reg,
   // port 1 queue manager and mac
   input  wire [3:0]  p1_q_pending,
   input  wire        p1_mac_ready,
   output wire        p1_grant_vld,
   output wire [1:0]  p1_grant_q,
   output wire [3:0]  p1_exhausted,
   // port 2 queue manager and mac
   input  wire [3:0]  p2_q_pending,
   input  wire        p2_mac_ready,
   output wire        p2_grant_vld,
   output wire [1:0]  p2_grant_q,
   output wire [3:0]  p2_exhausted
);
   wire [15:0] p1_high;
   wire [15:0] p1_low;
   wire [15:0] p2_high;
   wire [15:0] p2_low;
   reg  [31:0] period_cnt_reg;
   reg         period_start_reg;

   // separate register pair per port
   txq_rate_regs #(
      .HIGH_OFS (`P1_HIGH_QUEUES_RATE_OFS),
      .LOW_OFS  (`P1_LOW_QUEUES_RATE_OFS)
   ) u_p1_regs (
      .mclk     (mclk),
      .rstn     (rstn),
      .addr     (addr),
      .wdata    (wdata),
      .wr       (wr),
      .high_reg (p1_high),
      .low_reg  (p1_low)
   );

   txq_rate_regs #(
      .HIGH_OFS (`P2_HIGH_QUEUES_RATE_OFS),
      .LOW_OFS  (`P2_LOW_QUEUES_RATE_OFS)
   ) u_p2_regs (
      .mclk     (mclk),
      .rstn     (rstn),
      .addr     (addr),
      .wdata    (wdata),
      .wr       (wr),
      .high_reg (p2_high),
      .low_reg  (p2_low)
   );

   // shared period timer keeps both ports on the same time base
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         period_cnt_reg   <= 32'h0;
         period_start_reg <= 1'b0;
      end else if (period_cnt_reg >= PERIOD_CYCLES - 1) begin
         period_cnt_reg   <= 32'h0;
         period_start_reg <= 1'b1;
      end else begin
         period_cnt_reg   <= period_cnt_reg + 32'h1;
         period_start_reg <= 1'b0;
      end
   end

   txq_port_sched u_p1_sched (
      .mclk          (mclk),
      .rstn          (rstn),
      .high_reg      (p1_high),
      .low_reg       (p1_low),
      .period_start  (period_start_reg),
      .q_pending     (p1_q_pending),
      .mac_ready     (p1_mac_ready),
      .grant_vld_reg (p1_grant_vld),
      .grant_q_reg   (p1_grant_q),
      .exhausted_reg (p1_exhausted)
   );

   txq_port_sched u_p2_sched (
      .mclk          (mclk),
      .rstn          (rstn),
      .high_reg      (p2_high),
      .low_reg       (p2_low),
      .period_start  (period_start_reg),
      .q_pending     (p2_q_pending),
      .mac_ready     (p2_mac_ready),
      .grant_vld_reg (p2_grant_vld),
      .grant_q_reg   (p2_grant_q),
      .exhausted_reg (p2_exhausted)
   );

   // read data valid the cycle after rd only; unmapped reads zero
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 16'h0000;
      end else if (rd) begin
         case (addr)
            `P1_HIGH_QUEUES_RATE_OFS: rdata_reg <= p1_high;
            `P1_LOW_QUEUES_RATE_OFS:  rdata_reg <= p1_low;
            `P2_HIGH_QUEUES_RATE_OFS: rdata_reg <= p2_high;
            `P2_LOW_QUEUES_RATE_OFS:  rdata_reg <= p2_low;
            default:                  rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// File: verilog/txq_sched_regs.vh
`ifndef TXQ_SCHED_REGS_VH
`define TXQ_SCHED_REGS_VH
// register offsets (byte addresses, 16-bit registers)
`define P1_HIGH_QUEUES_RATE_OFS  8'hc8
`define P1_LOW_QUEUES_RATE_OFS   8'hca
`define P2_HIGH_QUEUES_RATE_OFS  8'hcc
`define P2_LOW_QUEUES_RATE_OFS   8'hce
// high register: queue 2 in upper byte, queue 3 in lower byte
// low register: queue 0 in upper byte, queue 1 in lower byte
`define UPPER_MODE_BIT           15
`define UPPER_RATIO_MSB          14
`define UPPER_RATIO_LSB          8
`define LOWER_MODE_BIT           7
`define LOWER_RATIO_MSB          6
`define LOWER_RATIO_LSB          0
`define HIGH_QUEUES_RATE_RESET   16'h8488
`define LOW_QUEUES_RATE_RESET    16'h8182
// scheduling period
`define PERIOD_US                10
`define CLK_MHZ                  50
`define PERIOD_CYCLES            (`PERIOD_US * `CLK_MHZ)
`endif

// File: verilog/txq_rate_regs.v
`include "txq_sched_regs.vh"
`default_nettype none
// one pair of rate registers for one network port
module txq_rate_regs #(
   parameter [7:0] HIGH_OFS = `P1_HIGH_QUEUES_RATE_OFS,
   parameter [7:0] LOW_OFS  = `P1_LOW_QUEUES_RATE_OFS
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // register write
   input  wire [7:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   // register contents
   output reg  [15:0] high_reg,
   output reg  [15:0] low_reg
);
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         high_reg <= `HIGH_QUEUES_RATE_RESET;
         low_reg  <= `LOW_QUEUES_RATE_RESET;
      end else if (wr) begin
         if (addr == HIGH_OFS) begin
            high_reg <= wdata;
         end
         if (addr == LOW_OFS) begin
            low_reg <= wdata;
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/txq_port_sched.v
`include "txq_sched_regs.vh"
`default_nettype none
// per-port four-queue scheduler; one grant per free mac slot
module txq_port_sched (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // configuration
   input  wire [15:0] high_reg,
   input  wire [15:0] low_reg,
   input  wire        period_start,
   // queue manager and mac
   input  wire [3:0]  q_pending,
   input  wire        mac_ready,
   output reg         grant_vld_reg,
   output reg  [1:0]  grant_q_reg,
   output reg  [3:0]  exhausted_reg
);
   wire [3:0] ratio_mode;
   wire [6:0] limit0;
   wire [6:0] limit1;
   wire [6:0] limit2;
   wire [6:0] limit3;
   reg  [6:0] cnt0_reg;
   reg  [6:0] cnt1_reg;
   reg  [6:0] cnt2_reg;
   reg  [6:0] cnt3_reg;
   reg  [3:0] eligible;
   reg  [3:0] pick;
   reg        pick_vld;
   reg  [1:0] pick_q;
   wire       issue;

   assign ratio_mode = {high_reg[`LOWER_MODE_BIT], high_reg[`UPPER_MODE_BIT],
                        low_reg[`LOWER_MODE_BIT], low_reg[`UPPER_MODE_BIT]};
   assign limit0 = low_reg[`UPPER_RATIO_MSB:`UPPER_RATIO_LSB];
   assign limit1 = low_reg[`LOWER_RATIO_MSB:`LOWER_RATIO_LSB];
   assign limit2 = high_reg[`UPPER_RATIO_MSB:`UPPER_RATIO_LSB];
   assign limit3 = high_reg[`LOWER_RATIO_MSB:`LOWER_RATIO_LSB];
   // a grant is offered only when the mac can take it
   assign issue = mac_ready & ~grant_vld_reg;

   always @* begin
      // ratio-mode queue at or over its count drops out; strict queues never do
      eligible[0] = q_pending[0] &
                    ~(ratio_mode[0] & (cnt0_reg >= limit0));
      eligible[1] = q_pending[1] &
                    ~(ratio_mode[1] & (cnt1_reg >= limit1));
      eligible[2] = q_pending[2] &
                    ~(ratio_mode[2] & (cnt2_reg >= limit2));
      eligible[3] = q_pending[3] &
                    ~(ratio_mode[3] & (cnt3_reg >= limit3));
      // nothing else waiting: an exhausted queue may still send
      pick = (eligible != 4'h0) ? eligible : q_pending;
      pick_vld = 1'b1;
      pick_q = 2'h0;
      // highest index wins: strict queues drain before lower ones
      if (pick[3]) begin
         pick_q = 2'h3;
      end else if (pick[2]) begin
         pick_q = 2'h2;
      end else if (pick[1]) begin
         pick_q = 2'h1;
      end else if (pick[0]) begin
         pick_q = 2'h0;
      end else begin
         pick_vld = 1'b0;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         grant_vld_reg <= 1'b0;
         grant_q_reg   <= 2'h0;
         cnt0_reg      <= 7'h00;
         cnt1_reg      <= 7'h00;
         cnt2_reg      <= 7'h00;
         cnt3_reg      <= 7'h00;
         exhausted_reg <= 4'h0;
      end else begin
         grant_vld_reg <= issue & pick_vld;
         if (issue & pick_vld) begin
            grant_q_reg <= pick_q;
         end
         if (period_start) begin
            cnt0_reg <= 7'h00;
            cnt1_reg <= 7'h00;
            cnt2_reg <= 7'h00;
            cnt3_reg <= 7'h00;
         end else if (issue & pick_vld) begin
            // saturate so a drained-anyway queue cannot wrap its count
            case (pick_q)
               2'h0: if (cnt0_reg != 7'h7f) cnt0_reg <= cnt0_reg + 7'h01;
               2'h1: if (cnt1_reg != 7'h7f) cnt1_reg <= cnt1_reg + 7'h01;
               2'h2: if (cnt2_reg != 7'h7f) cnt2_reg <= cnt2_reg + 7'h01;
               default: if (cnt3_reg != 7'h7f) cnt3_reg <= cnt3_reg + 7'h01;
            endcase
         end
         exhausted_reg <= ratio_mode &
            {cnt3_reg >= limit3, cnt2_reg >= limit2,
             cnt1_reg >= limit1, cnt0_reg >= limit0};
      end
   end
endmodule
`default_nettype wire

// File: verif/txq_sched_sva.sv
`default_nettype none
module txq_sched_sva (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rstn,
   // register port
   input wire logic [7:0]  addr,
   input wire logic        rd,
   input wire logic [15:0] rdata_reg,
   // network ports
   input wire logic [3:0]  p1_q_pending,
   input wire logic        p1_mac_ready,
   input wire logic        p1_grant_vld,
   input wire logic [1:0]  p1_grant_q,
   input wire logic        p2_mac_ready,
   input wire logic        p2_grant_vld,
   input wire logic [3:0]  p2_exhausted
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_p1_stall_quiet: assert property (
      !p1_mac_ready |=> !p1_grant_vld)
      else $error("port 1 grant while mac busy");
   a_p2_stall_quiet: assert property (
      !p2_mac_ready |=> !p2_grant_vld)
      else $error("port 2 grant while mac busy");
   a_p1_grant_pulse: assert property (
      p1_grant_vld |=> !p1_grant_vld)
      else $error("port 1 grant longer than one cycle");
   a_p2_grant_pulse: assert property (
      p2_grant_vld |=> !p2_grant_vld)
      else $error("port 2 grant longer than one cycle");
   a_grant_from_pending: assert property (
      p1_grant_vld |->
      (($past(p1_q_pending) >> p1_grant_q) & 4'h1) != 4'h0)
      else $error("port 1 granted an empty queue");
   a_pending_gets_grant: assert property (
      p1_mac_ready && !p1_grant_vld && p1_q_pending != 4'h0
      |=> p1_grant_vld)
      else $error("port 1 idle with packets waiting");
   a_grant_q_holds: assert property (
      !p1_grant_vld |-> $stable(p1_grant_q))
      else $error("port 1 queue number moved without grant");
   a_rdata_idle_zero: assert property (
      !$past(rd) |-> rdata_reg == 16'h0000)
      else $error("read data outside read slot");
   a_unmapped_read: assert property (
      $past(rd) && !($past(addr) inside {8'hc8, 8'hca, 8'hcc, 8'hce})
      |-> rdata_reg == 16'h0000)
      else $error("unmapped read returned data");
   c_p1_low_queue: cover property (p1_grant_vld && p1_grant_q == 2'h0);
   c_p2_all_spent: cover property (p2_exhausted == 4'hf);
   c_reg_read: cover property (rd ##1 rdata_reg != 16'h0000);
endmodule
bind txq_priority_rate_scheduler txq_sched_sva chk_u (.mclk, .rstn, .addr,
   .rd, .rdata_reg, .p1_q_pending, .p1_mac_ready, .p1_grant_vld, .p1_grant_q,
   .p2_mac_ready, .p2_grant_vld, .p2_exhausted);
`default_nettype wire

// File: verif/txq_far_side.sv
`default_nettype none
// queue manager and mac of one port; pending drops right after the grant
module txq_far_side (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // scheduler grants
   input  wire logic       grant_vld,
   input  wire logic [1:0] grant_q,
   // bench control
   input  wire logic       stall,
   // to scheduler
   output wire logic [3:0] q_pending,
   output wire logic       mac_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt [4];
   assign mac_ready = !stall;
   assign q_pending = {cnt[3] != 0, cnt[2] != 0, cnt[1] != 0, cnt[0] != 0};
   // called only while no grant is in flight, so the two writers never meet
   task automatic fill(input int a, input int b, input int c, input int d);
      cnt[0] <= cnt[0] + a;
      cnt[1] <= cnt[1] + b;
      cnt[2] <= cnt[2] + c;
      cnt[3] <= cnt[3] + d;
   endtask
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         cnt <= '{0, 0, 0, 0};
      else if (grant_vld && cnt[grant_q] > 0)
         cnt[grant_q] <= cnt[grant_q] - 1;
   end
endmodule
`default_nettype wire

// File: verif/txq_priority_rate_scheduler_test.sv
`default_nettype none
module txq_priority_rate_scheduler_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 100;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        s1 = 1'b0;
   logic        s2 = 1'b0;
   wire  [15:0] rdata_reg;
   wire  [3:0]  p1_q_pending, p2_q_pending, p1_exhausted, p2_exhausted;
   wire  [1:0]  p1_grant_q, p2_grant_q;
   wire         p1_mac_ready, p2_mac_ready, p1_grant_vld, p2_grant_vld;
   logic [1:0]  g1[$], g2[$];
   int          mismatches = 0, checks = 0, cyc = 0;
   always #10 mclk = ~mclk;
   txq_priority_rate_scheduler #(.PERIOD_CYCLES(P)) dut_u (.mclk, .rstn,
      .addr, .wdata, .wr, .rd, .rdata_reg, .p1_q_pending, .p1_mac_ready,
      .p1_grant_vld, .p1_grant_q, .p1_exhausted, .p2_q_pending,
      .p2_mac_ready, .p2_grant_vld, .p2_grant_q, .p2_exhausted);
   txq_far_side pm1 (.mclk, .rstn, .grant_vld(p1_grant_vld), .stall(s1),
      .grant_q(p1_grant_q), .q_pending(p1_q_pending),
      .mac_ready(p1_mac_ready));
   txq_far_side pm2 (.mclk, .rstn, .grant_vld(p2_grant_vld), .stall(s2),
      .grant_q(p2_grant_q), .q_pending(p2_q_pending),
      .mac_ready(p2_mac_ready));
   always @(posedge mclk) begin
      // non-blocking so every task woken on this edge reads one value
      cyc <= cyc + 1;
      if (p1_grant_vld === 1'b1) g1.push_back(p1_grant_q);
      if (p2_grant_vld === 1'b1) g2.push_back(p2_grant_q);
      if (cyc == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      check(rdata_reg, e);
      @(posedge mclk);
   endtask
   // grants are compared in order; expected list packed first grant on top
   task automatic drain(input bit p2, input int n, input logic [63:0] e);
      int i;
      i = 0;
      while ((p2 ? g2.size() : g1.size()) < n && i < 300) begin
         @(posedge mclk);
         i++;
      end
      for (i = 0; i < n; i++)
         check(p2 ? g2[i] : g1[i], e[2*(n-1-i) +: 2]);
      g1 = {};
      g2 = {};
   endtask
   // the bench cannot see the period strobe, so it aligns by cycle count
   task automatic wait_off(input int o);
      while (cyc % P != o) @(posedge mclk);
   endtask
   task automatic regs_test;
      rd_chk(8'hc8, 16'h8488);
      rd_chk(8'hca, 16'h8182);
      rd_chk(8'hcc, 16'h8488);
      rd_chk(8'hce, 16'h8182);
      wr_reg(8'hd0, 16'hffff);
      rd_chk(8'hd0, 16'h0000);
   endtask
   task automatic strict_test;
      wr_reg(8'hc8, 16'h0000);
      wr_reg(8'hca, 16'h0000);
      rd_chk(8'hc8, 16'h0000);
      rd_chk(8'hcc, 16'h8488);
      s1 <= 1'b1;
      pm1.fill(2, 2, 2, 2);
      repeat (4) @(posedge mclk);
      check(g1.size(), 16'h0000);
      s1 <= 1'b0;
      drain(0, 8, 64'hfa50);
   endtask
   task automatic ratio_test;
      wait_off(5);
      // a short mac stall first, so port 2 also sees a refused slot
      s2 <= 1'b1;
      pm2.fill(2, 3, 5, 10);
      repeat (2) @(posedge mclk);
      check(g2.size(), 16'h0000);
      s2 <= 1'b0;
      drain(1, 20,
         64'hffffaa53e4);
      @(negedge mclk);
      check(p2_exhausted, 16'h000f);
      wait_off(5);
      @(negedge mclk);
      check(p2_exhausted, 16'h0000);
      @(posedge mclk);
      wr_reg(8'hc8, 16'h8180);
      pm1.fill(0, 1, 2, 1);
      drain(0, 4, 64'h9e);
      // queue 3 has a zero count and queue 2 spent its one; 1 and 0 strict
      @(negedge mclk);
      check(p1_exhausted, 16'h000c);
   endtask
   task automatic conclude;
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      regs_test();
      strict_test();
      ratio_test();
      conclude();
   end
endmodule
`default_nettype wire
